// ===== core/phase_overcurrent_stage.sv
`timescale 1ns/1ns
// Contract
// - eight setting groups, one chosen by common select input, changeable live
// - settings and block input may change while running, effective at once
// - instant mode or delayed mode with definite or inverse delay
// - saturation check keeps start and trip working under saturated current
// - on and off events for start, trip and blocked, with stamp
// - instant mode issues start and trip events together, same stamp
// - event stamps count whole milliseconds
// - separate resettable counters of start, trip and blocked events
// - magnitude select: 1 rms (default), 2 true-rms, 3 peak-to-peak
// - peak-to-peak taken directly from raw samples
// - true-rms includes harmonics up to the 32nd
// - pre-fault data is 20 ms average ending at start or trip
// - remote threshold change: 1 disabled (default), 2 allowed
// - general settings stay fixed across group changes
// - forced state codes honoured only while forcing globally enabled
// - any phase above common threshold picks up
// - phase drops off below 97 percent of threshold
// - threshold 0.10 to 50.00 nominal, 0.01 steps, default 1.20
// - start needs pick-up and inactive block input
// - block at pick-up gives blocked, drops start, resets timing
module phase_overcurrent_stage #(
   parameter int MS_CYCLES = oc_pkg::MS_NS / oc_pkg::CLK_NS
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire oc_pkg::phase_meas_s [2:0] meas,
   input wire logic measValid,
   input wire logic [2:0][15:0] rawSample,
   input wire logic sampleValid,
   input wire logic blockIn,
   input wire logic [oc_pkg::GRP_W-1:0] groupSel,
   input wire logic forceEnable,
   output logic startOut,
   output logic tripOut,
   output logic blockedOut,
   output logic [2:0] phaseStart,
   output logic [2:0] phaseTrip,
   output oc_pkg::event_s eventOut
);
   import oc_pkg::*;
   logic [PRE_W-1:0] prescale;
   logic msTick;
   logic [STAMP_W-1:0] stamp;
   general_s gen;
   logic [15:0] thr [NGRP];
   logic [1:0] mode [NGRP];
   logic [15:0] delay [NGRP];
   logic [15:0] phaseMag [3];
   logic [15:0] ppVal [3];
   logic [2:0] phUp;
   logic [15:0] pre [3];
   logic [CNT_W-1:0] cnt [3];
   logic [2:0] cntClr;
   stage_e state, next_state;
   logic [31:0] opAcc, opLimit;
   logic [7:0] pendAddr;
   logic pendWrite, dataPhase, addrOk;
   logic [31:0] readMux;
   logic [15:0] thrNow, maxMag;
   logic [1:0] modeNow;
   logic anyUp, forcing, timerDone, wrEn;
   forced_s f;
   logic next_start, next_trip, next_blocked;
   logic [2:0] next_phStart, next_phTrip, curVec, nextVec;

   // 1 ms time base for stamps and delay timing
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         prescale <= '0;
         msTick <= 1'b0;
         stamp <= '0;
      end else if (prescale == PRE_W'(MS_CYCLES - 1)) begin
         prescale <= '0;
         msTick <= 1'b1;
         stamp <= stamp + 1'b1;
      end else begin
         prescale <= prescale + 1'b1;
         msTick <= 1'b0;
      end
   end
   // active group; the select may move at any time
   assign thrNow = thr[groupSel];
   assign modeNow = mode[groupSel];
   // per-phase magnitude path
   for (genvar g = 0; g < 3; g++) begin : g_phase
      logic signed [15:0] hi, lo;
      logic [15:0] sel;
      logic [18:0] trueScaled, rmsScaled;
      logic [22:0] magPct, thrPct;
      logic [15:0] hist [4];
      logic [17:0] histSum;
      // peak-to-peak straight from raw samples over each 5 ms window
      always_ff @(posedge clk or negedge reset_n) begin
         if (!reset_n) begin
            hi <= 16'sh8000;
            lo <= 16'sh7FFF;
            ppVal[g] <= '0;
         end else if (measValid) begin
            ppVal[g] <= 16'(hi - lo);
            hi <= 16'sh8000;
            lo <= 16'sh7FFF;
         end else if (sampleValid) begin
            if ($signed(rawSample[g]) > hi) hi <= $signed(rawSample[g]);
            if ($signed(rawSample[g]) < lo) lo <= $signed(rawSample[g]);
         end
      end
      // true-rms input already carries harmonics up to the 32nd
      always_comb begin
         case (gen.magSel)
            MAG_TRUE: sel = meas[g].trueRms;
            MAG_PP: sel = ppVal[g];
            default: sel = meas[g].rms;
         endcase
         trueScaled = 19'(meas[g].trueRms) * 19'(SAT_DEN);
         rmsScaled = 19'(meas[g].rms) * 19'(SAT_NUM);
         magPct = 23'(phaseMag[g]) * 23'(FULL_PCT);
         thrPct = 23'(thrNow) * 23'(DROP_PCT);
         histSum = 18'(hist[0]) + 18'(hist[1]) + 18'(hist[2]) + 18'(hist[3]);
      end
      // a saturated core flattens the fundamental, so fall back to true-rms
      always_ff @(posedge clk or negedge reset_n) begin
         if (!reset_n) phaseMag[g] <= '0;
         else if (trueScaled > rmsScaled && meas[g].trueRms > sel)
            phaseMag[g] <= meas[g].trueRms;
         else phaseMag[g] <= sel;
      end
      // comparator with fixed 97 percent reset ratio
      always_ff @(posedge clk or negedge reset_n) begin
         if (!reset_n) phUp[g] <= 1'b0;
         else if (phaseMag[g] > thrNow) phUp[g] <= 1'b1;
         else if (magPct < thrPct) phUp[g] <= 1'b0;
      end
      // four 5 ms values make the 20 ms history
      always_ff @(posedge clk or negedge reset_n) begin
         if (!reset_n) begin
            for (int i = 0; i < 4; i++) hist[i] <= '0;
            pre[g] <= '0;
         end else begin
            if (measValid) begin
               hist[0] <= phaseMag[g];
               for (int i = 1; i < 4; i++) hist[i] <= hist[i-1];
            end
            if (nextVec[EV_START] & ~curVec[EV_START] | nextVec[EV_TRIP] & ~curVec[EV_TRIP])
               pre[g] <= histSum[17:2];
         end
      end
   end

   always_comb begin
      maxMag = phaseMag[0];
      if (phaseMag[1] > maxMag) maxMag = phaseMag[1];
      if (phaseMag[2] > maxMag) maxMag = phaseMag[2];
   end

   assign anyUp = |phUp;
   assign forcing = forceEnable && gen.forceSel != '0;
   assign opLimit = (modeNow == MODE_INV) ? 32'(delay[groupSel]) * 32'(thrNow)
                                          : 32'(delay[groupSel]);
   assign timerDone = opAcc >= opLimit;
   // stage decision; block only matters while picked up
   always_comb begin
      case (state)
         ST_TRIP: begin
            if (!anyUp) next_state = ST_NORMAL;
            else if (blockIn) next_state = ST_BLOCKED;
            else next_state = ST_TRIP;
         end
         default: begin
            if (!anyUp) next_state = ST_NORMAL;
            else if (blockIn) next_state = ST_BLOCKED;
            else if (modeNow == MODE_INST || timerDone) next_state = ST_TRIP;
            else next_state = ST_START;
         end
      endcase
   end
   // operate timer: inverse mode integrates current, so big faults trip sooner
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) opAcc <= '0;
      else if (state != ST_START) opAcc <= '0;
      else if (msTick)
         opAcc <= opAcc + ((modeNow == MODE_INV) ? 32'(maxMag) : 32'h1);
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) state <= ST_NORMAL;
      else state <= next_state;
   end
   // forced state table
   always_comb begin
      f = '0;
      case (gen.forceSel)
         5'h01: f.start = 1'b1;
         5'h02: {f.start, f.trip} = 2'h3;
         5'h03: f.blk = 1'b1;
         5'h04, 5'h05, 5'h06: begin
            f.start = 1'b1;
            f.phStart = 3'h1 << (gen.forceSel - 5'h04);
         end
         5'h07, 5'h08, 5'h09: begin
            {f.start, f.trip} = 2'h3;
            f.phStart = 3'h1 << (gen.forceSel - 5'h07);
            f.phTrip = f.phStart;
         end
         5'h0A: {f.start, f.phStart} = 4'hB;
         5'h0B: {f.start, f.phStart} = 4'hE;
         5'h0C: {f.start, f.phStart} = 4'hD;
         5'h0D: {f.start, f.phStart} = 4'hF;
         5'h0E: {f.start, f.trip, f.phTrip, f.phStart} = 8'hDB;
         5'h0F: {f.start, f.trip, f.phTrip, f.phStart} = 8'hF6;
         5'h10: {f.start, f.trip, f.phTrip, f.phStart} = 8'hED;
         5'h11: {f.start, f.trip, f.phTrip, f.phStart} = 8'hFF;
         default: f = '0;
      endcase
      next_start = forcing ? f.start : (next_state == ST_START || next_state == ST_TRIP);
      next_trip = forcing ? f.trip : next_state == ST_TRIP;
      next_blocked = forcing ? f.blk : next_state == ST_BLOCKED;
      next_phStart = forcing ? f.phStart : phUp & {3{next_start}};
      next_phTrip = forcing ? f.phTrip : phUp & {3{next_trip}};
      curVec = {blockedOut, tripOut, startOut};
      nextVec = {next_blocked, next_trip, next_start};
   end
   // outputs and events leave on the same edge with one stamp
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         {startOut, tripOut, blockedOut} <= '0;
         phaseStart <= '0;
         phaseTrip <= '0;
         eventOut <= '0;
      end else begin
         {blockedOut, tripOut, startOut} <= nextVec;
         phaseStart <= next_phStart;
         phaseTrip <= next_phTrip;
         eventOut.on <= nextVec & ~curVec;
         eventOut.off <= ~nextVec & curVec;
         eventOut.valid <= nextVec != curVec;
         eventOut.stamp <= stamp;
      end
   end
   // counters; a new event beats a clear in the same cycle
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) for (int i = 0; i < 3; i++) cnt[i] <= '0;
      else for (int i = 0; i < 3; i++) begin
         if (nextVec[i] & ~curVec[i])
            cnt[i] <= cntClr[i] ? CNT_W'(1) : cnt[i] + 1'b1;
         else if (cntClr[i]) cnt[i] <= '0;
      end
   end
   // AHB-Lite slave: one wait state so reads see any preceding write
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pendAddr <= '0;
         pendWrite <= 1'b0;
         addrOk <= 1'b0;
         dataPhase <= 1'b0;
         hreadyout <= 1'b1;
         hrdata <= '0;
      end else if (hsel && htrans[1] && hready) begin
         pendAddr <= haddr[7:0];
         pendWrite <= hwrite;
         addrOk <= haddr[31:8] == '0;
         dataPhase <= 1'b1;
         hreadyout <= 1'b0;
      end else if (dataPhase) begin
         dataPhase <= 1'b0;
         hreadyout <= 1'b1;
         if (!pendWrite) hrdata <= readMux;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) hresp <= 1'b0;
      else hresp <= 1'b0;
   end

   assign wrEn = dataPhase && pendWrite && addrOk;

   // unmapped addresses read zero
   always_comb begin
      readMux = '0;
      if (addrOk) begin
         if ((pendAddr & GRP_MASK) == OFF_GRP)
            readMux = pendAddr[2] ? 32'(delay[pendAddr[5:3]])
                                  : 32'({mode[pendAddr[5:3]], thr[pendAddr[5:3]]});
         else case (pendAddr)
            OFF_GEN: readMux = 32'(gen);
            OFF_STAT: readMux = 32'({groupSel, state, phaseTrip, phaseStart,
                                     blockedOut, tripOut, startOut});
            OFF_CNT: readMux = 32'(cnt[EV_START]);
            OFF_CNT + 8'h04: readMux = 32'(cnt[EV_TRIP]);
            OFF_CNT + 8'h08: readMux = 32'(cnt[EV_BLOCK]);
            OFF_PRE: readMux = 32'(pre[0]);
            OFF_PRE + 8'h04: readMux = 32'(pre[1]);
            OFF_PRE + 8'h08: readMux = 32'(pre[2]);
            OFF_COMM: readMux = 32'(thrNow);
            default: readMux = '0;
         endcase
      end
   end
   // general settings live outside the groups
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) gen <= '{forceSel: '0, remoteCtl: REM_OFF, magSel: MAG_RMS};
      else if (wrEn && pendAddr == OFF_GEN) gen <= hwdata[$bits(general_s)-1:0];
   end
   // counter clear strobes
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) cntClr <= '0;
      else cntClr <= (wrEn && pendAddr == OFF_CTRL) ? hwdata[2:0] : 3'h0;
   end

   // group settings; threshold clamped to its legal range
   function automatic logic [15:0] clampThr(input logic [15:0] v);
      if (v < THR_MIN) return THR_MIN;
      if (v > THR_MAX) return THR_MAX;
      return v;
   endfunction : clampThr

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < NGRP; i++) begin
            thr[i] <= THR_DEF;
            mode[i] <= MODE_DEF;
            delay[i] <= DELAY_DEF;
         end
      end else if (wrEn) begin
         if ((pendAddr & GRP_MASK) == OFF_GRP) begin
            if (pendAddr[2]) delay[pendAddr[5:3]] <= hwdata[15:0];
            else begin
               thr[pendAddr[5:3]] <= clampThr(hwdata[15:0]);
               mode[pendAddr[5:3]] <= hwdata[17:16];
            end
         end else if (pendAddr == OFF_COMM && gen.remoteCtl == REM_ON)
            thr[groupSel] <= clampThr(hwdata[15:0]);
      end
   end

   // checks
   block_gates_a: assert property (@(posedge clk) disable iff (!reset_n)
      $past(blockIn) && !$past(forcing) |-> !startOut)
      else $error("start asserted while block input active");
   blocked_out_a: assert property (@(posedge clk) disable iff (!reset_n)
      $past(anyUp && blockIn && !forcing) |-> blockedOut && !tripOut)
      else $error("blocked not shown on blocked pick-up");
   start_event_a: assert property (@(posedge clk) disable iff (!reset_n)
      $rose(startOut) |-> eventOut.valid && eventOut.on[EV_START])
      else $error("start on event missing");
   trip_off_a: assert property (@(posedge clk) disable iff (!reset_n)
      $fell(tripOut) |-> eventOut.valid && eventOut.off[EV_TRIP])
      else $error("trip off event missing");
   instant_trip_a: assert property (@(posedge clk) disable iff (!reset_n)
      $past(anyUp && !blockIn && modeNow == MODE_INST && !forcing)
      |-> tripOut && startOut)
      else $error("instant mode did not start and trip together");
   drop_hyst_a: assert property (@(posedge clk) disable iff (!reset_n)
      $past(phUp[0]) && $past(phaseMag[0]) >= $past(thrNow) |-> phUp[0])
      else $error("phase dropped above threshold");
   trip_count_a: assert property (@(posedge clk) disable iff (!reset_n)
      eventOut.on[EV_TRIP] && !$past(cntClr[EV_TRIP])
      |-> cnt[EV_TRIP] == CNT_W'($past(cnt[EV_TRIP]) + 1'b1))
      else $error("trip counter did not advance");
   stamp_step_a: assert property (@(posedge clk) disable iff (!reset_n)
      msTick |-> stamp == STAMP_W'($past(stamp) + 1'b1) ##1 $stable(stamp))
      else $error("stamp not advanced once per millisecond");
   bus_wait_a: assert property (@(posedge clk) disable iff (!reset_n)
      hsel && htrans[1] && hready |=> !hreadyout ##1 hreadyout)
      else $error("bus answer not one wait state");
   remote_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
      wrEn && pendAddr == OFF_COMM && gen.remoteCtl != REM_ON
      |=> $stable(thrNow) || $changed(groupSel))
      else $error("threshold changed with remote control disabled");
   force_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
      $past(!forceEnable && !anyUp) |-> !startOut && !tripOut && !blockedOut)
      else $error("forced state honoured while forcing disabled");
   cover_instant_c: cover property (@(posedge clk) disable iff (!reset_n)
      eventOut.on[EV_START] && eventOut.on[EV_TRIP]);
   cover_blocked_c: cover property (@(posedge clk) disable iff (!reset_n)
      $fell(startOut) && blockedOut);
   cover_delayed_c: cover property (@(posedge clk) disable iff (!reset_n)
      state == ST_START ##1 state == ST_TRIP);
   cover_forced_c: cover property (@(posedge clk) disable iff (!reset_n)
      forcing && tripOut);
endmodule : phase_overcurrent_stage

// ===== core/oc_pkg.sv
package oc_pkg;
   // time base
   localparam int CLK_NS = 40;
   localparam int MS_NS = 1000000;
   localparam int PRE_W = 16;
   localparam int STAMP_W = 32;
   localparam int CNT_W = 16;
   localparam int MAG_W = 16;
   localparam int NGRP = 8;
   localparam int GRP_W = 3;
   // pick-up scaling, magnitudes in 0.01 x nominal
   localparam logic [15:0] THR_DEF = 16'h0078;
   localparam logic [15:0] THR_MIN = 16'h000A;
   localparam logic [15:0] THR_MAX = 16'h1388;
   localparam logic [6:0] DROP_PCT = 7'h61;
   localparam logic [6:0] FULL_PCT = 7'h64;
   localparam logic [15:0] DELAY_DEF = 16'h0064;
   // saturation when true-rms exceeds rms by 5/4
   localparam logic [2:0] SAT_NUM = 3'h5;
   localparam logic [2:0] SAT_DEN = 3'h4;
   // setting codes
   localparam logic [1:0] MAG_RMS = 2'h1;
   localparam logic [1:0] MAG_TRUE = 2'h2;
   localparam logic [1:0] MAG_PP = 2'h3;
   localparam logic [1:0] REM_OFF = 2'h1;
   localparam logic [1:0] REM_ON = 2'h2;
   localparam logic [1:0] MODE_INST = 2'h0;
   localparam logic [1:0] MODE_DEF = 2'h1;
   localparam logic [1:0] MODE_INV = 2'h2;
   localparam int EV_START = 0;
   localparam int EV_TRIP = 1;
   localparam int EV_BLOCK = 2;
   // register byte offsets
   localparam logic [7:0] OFF_GEN = 8'h00;
   localparam logic [7:0] OFF_CTRL = 8'h04;
   localparam logic [7:0] OFF_STAT = 8'h08;
   localparam logic [7:0] OFF_CNT = 8'h0C;
   localparam logic [7:0] OFF_PRE = 8'h18;
   localparam logic [7:0] OFF_COMM = 8'h24;
   localparam logic [7:0] OFF_GRP = 8'h40;
   localparam logic [7:0] GRP_MASK = 8'hC0;
   typedef enum logic [1:0] {ST_NORMAL, ST_START, ST_TRIP, ST_BLOCKED} stage_e;
   typedef struct packed {
      logic [15:0] rms;
      logic [15:0] trueRms;
      logic [15:0] peak;
   } phase_meas_s;
   typedef struct packed {
      logic [4:0] forceSel;
      logic [1:0] remoteCtl;
      logic [1:0] magSel;
   } general_s;
   typedef struct packed {
      logic valid;
      logic [2:0] on;
      logic [2:0] off;
      logic [STAMP_W-1:0] stamp;
   } event_s;
   typedef struct packed {
      logic blk;
      logic trip;
      logic start;
      logic [2:0] phTrip;
      logic [2:0] phStart;
   } forced_s;
endpackage : oc_pkg

// ===== dv/meas_source.sv
`timescale 1ns/1ns
// stands in for the measurement front end: 5 ms refreshes and raw samples
module meas_source
   import oc_pkg::*;
#(
   parameter int MS_CYCLES = 10
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire oc_pkg::phase_meas_s [2:0] level,
   input wire logic [15:0] ppAmp,
   output oc_pkg::phase_meas_s [2:0] meas,
   output logic measValid,
   output logic [2:0][15:0] rawSample,
   output logic sampleValid
);
   int tick;
   // values change only with the strobe, so the stage never sees a half refresh
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         tick <= 0;
         measValid <= 1'b0;
         sampleValid <= 1'b0;
         meas <= '0;
         rawSample <= '0;
      end else begin
         tick <= (tick == 5 * MS_CYCLES - 1) ? 0 : tick + 1;
         measValid <= (tick == 5 * MS_CYCLES - 1);
         sampleValid <= tick[0];
         if (tick == 5 * MS_CYCLES - 1) begin
            meas <= level;
         end
         // square wave, so peak-to-peak equals ppAmp in every window
         if (tick[0]) begin
            for (int p = 0; p < 3; p++) begin
               rawSample[p] <= tick[1] ? ppAmp >> 1 : 16'h0 - (ppAmp >> 1);
            end
         end
      end
   end
endmodule : meas_source

// ===== dv/tb_phase_overcurrent_stage.sv
`timescale 1ns/1ns
// drives the stage through its bus, measurement and control inputs
module tb_phase_overcurrent_stage;
   import oc_pkg::*;
   localparam int MS = 10;
   localparam int W = 5 * MS;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = '0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = '0;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   phase_meas_s [2:0] level = '0;
   phase_meas_s [2:0] meas;
   logic [15:0] ppAmp = '0;
   logic measValid;
   logic [2:0][15:0] rawSample;
   logic sampleValid;
   logic blockIn = 1'b0;
   logic [GRP_W-1:0] groupSel = '0;
   logic forceEnable = 1'b0;
   logic startOut;
   logic tripOut;
   logic blockedOut;
   logic [2:0] phaseStart;
   logic [2:0] phaseTrip;
   event_s eventOut;
   event_s lastEv = '0;
   logic [2:0] outs;
   int cyc = 0;
   int evCyc = 0;
   int bad_count = 0;
   int comparisons = 0;
   int n;
   int m;
   assign outs = {blockedOut, tripOut, startOut};
   // 25 MHz clock
   always #20 clk = ~clk;
   phase_overcurrent_stage #(.MS_CYCLES(MS)) u_phase_overcurrent_stage (
      .clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .meas(meas),
      .measValid(measValid), .rawSample(rawSample), .sampleValid(sampleValid),
      .blockIn(blockIn), .groupSel(groupSel), .forceEnable(forceEnable),
      .startOut(startOut), .tripOut(tripOut), .blockedOut(blockedOut),
      .phaseStart(phaseStart), .phaseTrip(phaseTrip), .eventOut(eventOut)
   );
   meas_source #(.MS_CYCLES(MS)) u_meas_source (
      .clk(clk), .reset_n(reset_n), .level(level), .ppAmp(ppAmp), .meas(meas),
      .measValid(measValid), .rawSample(rawSample), .sampleValid(sampleValid)
   );
   // keeps the latest event and the cycle it arrived in
   always @(posedge clk) begin
      cyc <= reset_n ? cyc + 1 : 0;
      if (eventOut.valid === 1'b1) begin
         lastEv <= eventOut;
         evCyc <= cyc;
      end
   end
   function automatic logic [31:0] ad(input logic [7:0] o);
      return {24'h0, o};
   endfunction : ad
   task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
      comparisons++;
      if (s !== e) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", what, e, s);
      end
   endtask : chk
   // one single transfer; the master never assumes how long the slave waits
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask : bus
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wr
   task automatic rdc(input logic [31:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk("register", e, q);
      chk("hresp", 32'h0, {31'h0, hresp});
   endtask : rdc
   task automatic lev(input int p, input logic [15:0] r, input logic [15:0] t);
      @(posedge clk);
      level[p] <= {r, t, 16'h0};
   endtask : lev
   // a fresh magnitude needs up to one 5 ms window plus the pipeline
   task automatic win(input int k);
      repeat (k * W + 8) @(posedge clk);
   endtask : win
   task automatic wait_for(input int w, output int c);
      c = 0;
      while (outs[w] !== 1'b1 && c < 400) begin
         @(posedge clk);
         c++;
      end
   endtask : wait_for
   task automatic close_out();
      $display("comparisons %0d bad_count %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : close_out
   // cuts a hang short; the tests need about 2000 cycles
   initial begin
      repeat (30000) @(posedge clk);
      bad_count++;
      close_out();
   end
   initial begin
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      rdc(ad(OFF_GEN), 32'h5);
      rdc(ad(OFF_GRP), 32'h0001_0078);
      rdc(ad(OFF_GRP) + 32'h4, 32'h64);
      rdc(32'h100, 32'h0);
      wr(ad(OFF_COMM), 32'hC8);
      rdc(ad(OFF_COMM), 32'h78);
      wr(ad(OFF_GRP) + 32'h18, 32'h5);
      rdc(ad(OFF_GRP) + 32'h18, 32'hA);
      wr(ad(OFF_GRP) + 32'h18, 32'hFFFF);
      rdc(ad(OFF_GRP) + 32'h18, 32'h1388);
      wr(ad(OFF_GRP) + 32'h8, 32'h64);
      wr(ad(OFF_GRP) + 32'h10, 32'h1_0064);
      wr(ad(OFF_GRP) + 32'h14, 32'hA);
      // instant group, fault on phase C only
      groupSel <= 3'h1;
      lev(2, 16'h96, 16'h96);
      win(2);
      chk("start", 1'b1, startOut);
      chk("trip", 1'b1, tripOut);
      chk("phases", 32'h24, {phaseTrip, phaseStart});
      chk("event on", 3'b011, lastEv.on);
      chk("stamp", 1'b1, (evCyc / MS - int'(lastEv.stamp)) inside {0, 1});
      lev(2, 16'h62, 16'h62);
      win(2);
      chk("hold", 1'b1, startOut);
      lev(2, 16'h60, 16'h60);
      win(2);
      chk("release", 1'b0, startOut);
      chk("event off", 3'b011, lastEv.off);
      // definite group of 10 ms, blocked part way and then left to trip
      groupSel <= 3'h2;
      lev(2, 16'h96, 16'h96);
      wait_for(0, n);
      repeat (5) @(posedge clk);
      blockIn <= 1'b1;
      repeat (10) @(posedge clk);
      chk("blocked", 3'b100, outs);
      blockIn <= 1'b0;
      wait_for(0, n);
      wait_for(1, m);
      chk("delay", 1'b1, m inside {[88:104]});
      lev(2, 16'h0, 16'h0);
      win(2);
      rdc(ad(OFF_CNT), 32'h3);
      rdc(ad(OFF_CNT) + 32'h4, 32'h2);
      rdc(ad(OFF_CNT) + 32'h8, 32'h1);
      wr(ad(OFF_CTRL), 32'h7);
      rdc(ad(OFF_CNT), 32'h0);
      rdc(ad(OFF_CNT) + 32'h8, 32'h0);
      // saturated phase A, then each magnitude source in turn
      groupSel <= 3'h1;
      lev(0, 16'h32, 16'h96);
      win(2);
      chk("saturated", 1'b1, startOut);
      lev(0, 16'h96, 16'h5A);
      win(2);
      chk("rms", 1'b1, startOut);
      wr(ad(OFF_GEN), 32'h6);
      win(2);
      chk("true rms", 1'b0, startOut);
      wr(ad(OFF_GEN), 32'h7);
      ppAmp <= 16'hC8;
      win(3);
      chk("peak", 1'b1, startOut);
      ppAmp <= 16'h0;
      lev(0, 16'h0, 16'h0);
      wr(ad(OFF_GEN), 32'h9);
      win(3);
      // threshold lowered over the comm path under a steady load
      wr(ad(OFF_COMM), 32'hC8);
      lev(1, 16'h96, 16'h96);
      win(5);
      chk("above load", 1'b0, startOut);
      wr(ad(OFF_COMM), 32'h64);
      repeat (10) @(posedge clk);
      chk("live change", 1'b1, startOut);
      rdc(ad(OFF_PRE) + 32'h4, 32'h96);
      groupSel <= 3'h2;
      rdc(ad(OFF_GEN), 32'h9);
      rdc(ad(OFF_GRP) + 32'h8, 32'h64);
      lev(1, 16'h0, 16'h0);
      win(2);
      // inverse group: twice the threshold fills delay*thr in five ms ticks
      wr(ad(OFF_GRP) + 32'h20, 32'h2_0064);
      wr(ad(OFF_GRP) + 32'h24, 32'hA);
      groupSel <= 3'h4;
      lev(1, 16'hC8, 16'hC8);
      wait_for(0, n);
      wait_for(1, m);
      chk("inverse delay", 1'b1, m inside {[40:53]});
      lev(1, 16'h0, 16'h0);
      win(2);
      // forcing is ignored until globally enabled
      wr(ad(OFF_GEN), 32'h29);
      repeat (10) @(posedge clk);
      chk("unforced", 1'b0, tripOut);
      forceEnable <= 1'b1;
      for (int c = 1; c < 4; c++) begin
         wr(ad(OFF_GEN), (c << 4) | 9);
         repeat (10) @(posedge clk);
         chk("forced", 1'b1, outs[c-1]);
      end
      forceEnable <= 1'b0;
      close_out();
   end
endmodule : tb_phase_overcurrent_stage
